// File: core/ext_event_line_ctrl_regs.vh
`ifndef EXT_EVENT_LINE_CTRL_REGS_VH
`define EXT_EVENT_LINE_CTRL_REGS_VH

// ----------------------------------------------------------------
// register offsets (byte addresses, word aligned)
// ----------------------------------------------------------------
`define OFS_RISE_SEL   6'h00
`define OFS_FALL_SEL   6'h04
`define OFS_SOFT_TRIG  6'h08
`define OFS_IRQ_MASK   6'h0c
`define OFS_EVT_MASK   6'h10
`define OFS_PENDING    6'h14
`define OFS_PORT_SEL0  6'h18
`define OFS_PORT_SEL1  6'h1c

// ----------------------------------------------------------------
// line layout
// ----------------------------------------------------------------
`define NUM_CFG        19
`define NUM_GPIO       16
`define NUM_PORTS      4
`define LINE_TOP       31
`define LINE_DIR_CLOCK 19
`define LINE_DIR_TIMER 29
`define LINE_SUPPLY    16
`define LINE_CMP1      17
`define LINE_CMP2      18
`define CFG_MASK       32'h0007ffff
`define IMASK_RESET    32'h00000000
`define EMASK_RESET    32'h00000000
`define ZERO32         32'h00000000

`endif

// File: core/ext_event_line_ctrl.v
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "ext_event_line_ctrl_regs.vh"

module ext_event_line_ctrl (
	input  wire        clk_i,       // 10 MHz bus clock
	input  wire        rst_i,       // synchronous reset, active high
	input  wire        cyc_i,       // wishbone cycle
	input  wire        stb_i,       // wishbone strobe
	input  wire        we_i,        // wishbone write enable
	input  wire [5:0]  adr_i,       // byte address
	input  wire [3:0]  sel_i,       // byte lane selects
	input  wire [31:0] dat_i,       // write data
	output reg  [31:0] dat_o,       // read data
	output reg         ack_o,       // wishbone acknowledge
	input  wire [63:0] gpio_i,      // four ports of sixteen pins
	input  wire        supply_i,    // supply monitor output
	input  wire        cmp1_i,      // comparator one output
	input  wire        cmp2_i,      // comparator two output
	input  wire        clock_evt_i, // real-time clock direct source
	input  wire        timer_evt_i, // low-power timer direct source
	output reg         irq_0_1_o,   // cpu irq, lines 0 and 1
	output reg         irq_2_3_o,   // cpu irq, lines 2 and 3
	output reg         irq_4_15_o,  // cpu irq, lines 4 to 15
	output reg         irq_supply_o,// cpu irq, line 16
	output reg         irq_cmp_o,   // cpu irq, lines 17 and 18
	output reg         irq_clock_o, // cpu irq, line 19
	output reg         irq_timer_o, // cpu irq, line 29
	output reg         cpu_event_o, // single cpu event input
	output reg         wakeup_o,    // wake-up to power management
	output reg         lp_block_o   // high forbids low-power entry
);

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg  [31:0] rise_sel;    // rising_trigger_select
reg  [31:0] fall_sel;    // falling_trigger_select
reg  [31:0] soft_trig;   // software_trigger_register
reg  [31:0] irq_mask;    // interrupt_mask_reg, 1 = unmasked
reg  [31:0] evt_mask;    // event mask, 1 = unmasked
reg  [31:0] pending;     // pending_flag_reg
reg  [31:0] port_sel0;   // 2-bit port select, lines 0..15
reg  [31:0] port_sel1;   // unused upper half reserved
reg  [31:0] sync1;       // synchroniser first stage
reg  [31:0] sync2;       // synchroniser second stage
reg  [31:0] prev;        // previous sample for edge detect
wire [31:0] raw;         // unsynchronised line levels
reg  [31:0] wmask;
wire        wr;
wire        rd;
wire [31:0] rise_edge;
wire [31:0] fall_edge;
wire [31:0] trig;
wire [31:0] rise_wr_blk;

// byte lane mask from sel_i
always @* begin
	wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
end

assign wr = cyc_i & stb_i & we_i & ~ack_o;
assign rd = cyc_i & stb_i & ~we_i & ~ack_o;

// ----------------------------------------------------------------
// line sources
// ----------------------------------------------------------------
// each gpio line picks pin n of one of the ports
genvar g;
generate
	for (g = 0; g < `NUM_GPIO; g = g + 1) begin : gpio_mux
		assign raw[g] = gpio_i[port_sel0[2*g +: 2] * `NUM_GPIO + g];
	end
endgenerate

// fixed source map, reserved lines tied low so they never trigger
assign raw[`LINE_SUPPLY]    = supply_i;
assign raw[`LINE_CMP1]      = cmp1_i;
assign raw[`LINE_CMP2]      = cmp2_i;
assign raw[`LINE_DIR_CLOCK] = clock_evt_i;
assign raw[`LINE_DIR_TIMER-1:`LINE_DIR_CLOCK+1] = 9'h000;
assign raw[`LINE_DIR_TIMER] = timer_evt_i;
assign raw[`LINE_TOP:`LINE_DIR_TIMER+1] = 2'h0;

// ----------------------------------------------------------------
// synchroniser and edge detection
// ----------------------------------------------------------------
// first stage feeds only the second; edges come from stage two
always @(posedge clk_i) begin
	if (rst_i) begin
		sync1 <= `ZERO32;
		sync2 <= `ZERO32;
		prev  <= `ZERO32;
	end else begin
		sync1 <= raw;
		sync2 <= sync1;
		prev  <= sync2;
	end
end

// glitches are not filtered: every edge here reaches the trigger logic, which keeps every direct-line rise and selected edges not hit by a rise_sel write
assign rise_edge = sync2 & ~prev;
assign fall_edge = ~sync2 & prev;

// a configurable line's rising edge colliding with a rising-select write to its byte lane is dropped
assign rise_wr_blk = (wr && adr_i == `OFS_RISE_SEL) ? wmask : `ZERO32;

// configurable lines: selected edges or software; direct lines: rising only
assign trig = (((rise_edge & rise_sel & ~rise_wr_blk) | (fall_edge & fall_sel)
	| soft_trig) & `CFG_MASK)
	| (rise_edge & ~`CFG_MASK);

// ----------------------------------------------------------------
// register writes, pending and software trigger
// ----------------------------------------------------------------
always @(posedge clk_i) begin
	if (rst_i) begin
		rise_sel  <= `ZERO32;
		fall_sel  <= `ZERO32;
		soft_trig <= `ZERO32;
		irq_mask  <= `IMASK_RESET;
		evt_mask  <= `EMASK_RESET;
		pending   <= `ZERO32;
		port_sel0 <= `ZERO32;
		port_sel1 <= `ZERO32;
	end else begin
		// software bit lives one cycle, then hardware clears it
		soft_trig <= `ZERO32;
		// set wins over a same-cycle write-one clear
		pending <= ((pending & ~((wr && adr_i == `OFS_PENDING) ?
			(dat_i & wmask) : `ZERO32))
			| (trig & irq_mask)) & `CFG_MASK;
		if (wr) begin
			case (adr_i)
				`OFS_RISE_SEL: begin
					rise_sel <= ((rise_sel & ~wmask) | (dat_i & wmask)) & `CFG_MASK;
				end
				`OFS_FALL_SEL: begin
					fall_sel <= ((fall_sel & ~wmask) | (dat_i & wmask)) & `CFG_MASK;
				end
				`OFS_SOFT_TRIG: begin
					soft_trig <= dat_i & wmask & `CFG_MASK;
				end
				`OFS_IRQ_MASK: begin
					irq_mask <= (irq_mask & ~wmask) | (dat_i & wmask);
				end
				`OFS_EVT_MASK: begin
					evt_mask <= (evt_mask & ~wmask) | (dat_i & wmask);
				end
				`OFS_PORT_SEL0: begin
					port_sel0 <= (port_sel0 & ~wmask) | (dat_i & wmask);
				end
				`OFS_PORT_SEL1: begin
					port_sel1 <= (port_sel1 & ~wmask) | (dat_i & wmask);
				end
				default: begin
					port_sel1 <= port_sel1;
				end
			endcase
		end
	end
end

// ----------------------------------------------------------------
// wishbone answer: ack one cycle after request, unmapped reads zero
// ----------------------------------------------------------------
always @(posedge clk_i) begin
	if (rst_i) begin
		ack_o <= 1'b0;
		dat_o <= `ZERO32;
	end else begin
		ack_o <= cyc_i & stb_i & ~ack_o;
		if (rd) begin
			case (adr_i)
				`OFS_RISE_SEL:  dat_o <= rise_sel;
				`OFS_FALL_SEL:  dat_o <= fall_sel;
				`OFS_SOFT_TRIG: dat_o <= soft_trig;
				`OFS_IRQ_MASK:  dat_o <= irq_mask;
				`OFS_EVT_MASK:  dat_o <= evt_mask;
				`OFS_PENDING:   dat_o <= pending;
				`OFS_PORT_SEL0: dat_o <= port_sel0;
				`OFS_PORT_SEL1: dat_o <= port_sel1;
				default:        dat_o <= `ZERO32;
			endcase
		end
	end
end

// ----------------------------------------------------------------
// request outputs
// ----------------------------------------------------------------
// configurable irqs follow pending; direct irqs are one-cycle pulses
// because the flag lives in the source peripheral
always @(posedge clk_i) begin
	if (rst_i) begin
		irq_0_1_o    <= 1'b0;
		irq_2_3_o    <= 1'b0;
		irq_4_15_o   <= 1'b0;
		irq_supply_o <= 1'b0;
		irq_cmp_o    <= 1'b0;
		irq_clock_o  <= 1'b0;
		irq_timer_o  <= 1'b0;
		cpu_event_o  <= 1'b0;
		wakeup_o     <= 1'b0;
		lp_block_o   <= 1'b0;
	end else begin
		irq_0_1_o    <= |pending[1:0];
		irq_2_3_o    <= |pending[3:2];
		irq_4_15_o   <= |pending[15:4];
		irq_supply_o <= pending[`LINE_SUPPLY];
		irq_cmp_o    <= pending[`LINE_CMP1] | pending[`LINE_CMP2];
		irq_clock_o  <= trig[`LINE_DIR_CLOCK] & irq_mask[`LINE_DIR_CLOCK];
		irq_timer_o  <= trig[`LINE_DIR_TIMER] & irq_mask[`LINE_DIR_TIMER];
		cpu_event_o  <= |(trig & evt_mask);
		// wake on any unmasked trigger, usable in stop and run alike
		wakeup_o     <= |(trig & (irq_mask | evt_mask));
		lp_block_o   <= |pending;
	end
end

endmodule

// File: bench/eelc_asserts.sv
`timescale 1ns/1ps
module eelc_asserts (
	input logic clk_i,        // bus clock
	input logic rst_i,        // sync reset
	input logic cyc_i,        // bus cycle
	input logic stb_i,        // bus strobe
	input logic ack_o,        // bus ack
	input logic clock_evt_i,  // clock source
	input logic irq_0_1_o,    // irq 0-1
	input logic irq_2_3_o,    // irq 2-3
	input logic irq_4_15_o,   // irq 4-15
	input logic irq_supply_o, // irq 16
	input logic irq_cmp_o,    // irq 17-18
	input logic irq_clock_o,  // irq 19
	input logic irq_timer_o,  // irq 29
	input logic cpu_event_o,  // cpu event
	input logic wakeup_o,     // wake-up
	input logic lp_block_o    // low-power block
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// any level irq means some pending bit was set one cycle earlier
	wire lvl = irq_0_1_o | irq_2_3_o | irq_4_15_o | irq_supply_o | irq_cmp_o;
	a_ack_follows_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack missing after request");
	a_ack_one_cycle: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_ack_has_req: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	a_level_blocks_lp: assert property (lvl |-> lp_block_o)
		else $error("pending irq without low-power block");
	a_clock_single_pulse: assert property (irq_clock_o |=> !irq_clock_o)
		else $error("clock irq not a single pulse");
	a_timer_single_pulse: assert property (irq_timer_o |=> !irq_timer_o)
		else $error("timer irq not a single pulse");
	a_direct_wakes: assert property (irq_clock_o || irq_timer_o |-> wakeup_o)
		else $error("direct irq without wake-up");
	a_event_wakes: assert property (cpu_event_o |-> wakeup_o)
		else $error("event without wake-up");
	a_clock_has_cause: assert property (irq_clock_o |-> $past(clock_evt_i, 2))
		else $error("clock irq without source edge");
	c_gpio_irq: cover property (irq_4_15_o);
	c_timer_irq: cover property (irq_timer_o);
	c_event: cover property (cpu_event_o);
endmodule
bind ext_event_line_ctrl eelc_asserts u_chk (.*);

// File: bench/evt_src_model.sv
`timescale 1ns/1ps
module evt_src_model (
	input  logic        clk_i,    // bus clock
	output logic [68:0] lines_o   // gpio 0-63, supply, cmp1, cmp2, clock, timer
);
	initial lines_o = '0;
	// one clean level step per call, so no glitch reaches a line
	task pin(input int b, input logic v);
		@(posedge clk_i);
		lines_o[b] <= v;
	endtask
endmodule

// File: bench/ext_event_line_ctrl_test.sv
`timescale 1ns/1ps
module ext_event_line_ctrl_test;
	logic        clk_i = 0;
	logic        rst_i = 1;
	logic        cyc_i = 0;
	logic        stb_i = 0;
	logic        we_i = 0;
	logic [5:0]  adr_i = 0;
	logic [3:0]  sel_i = 0;
	logic [31:0] dat_i = 0;
	logic [31:0] dat_o;
	logic [31:0] rd;
	logic        ack_o, s;
	wire  [68:0] lv;
	wire  [9:0]  q;
	int          err_total = 0;
	int          num_checks = 0;
	evt_src_model SRC (.clk_i, .lines_o(lv));
	ext_event_line_ctrl DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
		.dat_o, .ack_o, .gpio_i(lv[63:0]), .supply_i(lv[64]), .cmp1_i(lv[65]),
		.cmp2_i(lv[66]), .clock_evt_i(lv[67]), .timer_evt_i(lv[68]), .irq_0_1_o(q[0]),
		.irq_2_3_o(q[1]), .irq_4_15_o(q[2]), .irq_supply_o(q[3]), .irq_cmp_o(q[4]),
		.irq_clock_o(q[5]), .irq_timer_o(q[6]), .cpu_event_o(q[7]), .wakeup_o(q[8]),
		.lp_block_o(q[9]));
	initial forever #50 clk_i = ~clk_i;
	task final_report;
		if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// single classic cycle, held until ack is sampled high
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] m);
		int n;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, m};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		rd = dat_o;
		{cyc_i, stb_i, we_i} <= 3'b000;
		if (n >= 20) begin
			err_total++;
			final_report;
		end
	endtask
	task rchk(input logic [5:0] a, input logic [31:0] e);
		bus(0, a, 0, 4'hf);
		chk($sformatf("reg %h", a), e, rd);
	endtask
	// looks for output i over the fixed line latency window
	task seen(input int i, input logic e);
		s = 0;
		repeat (8) begin
			@(negedge clk_i);
			s = s | q[i];
		end
		chk($sformatf("out %0d", i), e, s);
	endtask
	task t_regs;
		rchk(6'h00, 0);
		rchk(6'h04, 0);
		bus(1, 6'h00, 32'hffffffff, 4'hf);
		rchk(6'h00, 32'h0007ffff);
		bus(1, 6'h04, 32'h000001ff, 4'h1);
		rchk(6'h04, 32'h000000ff);
		bus(1, 6'h04, 0, 4'hf);
		bus(1, 6'h00, 0, 4'hf);
		rchk(6'h20, 0);
	endtask
	task t_gpio;
		bus(1, 6'h0c, 32'h00000020, 4'hf);
		bus(1, 6'h00, 32'h00000020, 4'hf);
		SRC.pin(5, 1);
		seen(2, 1);
		rchk(6'h14, 32'h00000020);
		chk("lp_block", 1, q[9]);
		bus(1, 6'h14, 0, 4'hf);
		rchk(6'h14, 32'h00000020);
		bus(1, 6'h14, 32'h00000020, 4'hf);
		rchk(6'h14, 0);
		bus(1, 6'h04, 32'h00000020, 4'hf);
		SRC.pin(5, 0);
		seen(9, 1);
		bus(1, 6'h14, 32'h00000020, 4'hf);
	endtask
	task t_mask;
		bus(1, 6'h00, 32'h00000001, 4'hf);
		bus(1, 6'h10, 32'h00000001, 4'hf);
		SRC.pin(0, 1);
		seen(7, 1);
		rchk(6'h14, 0);
	endtask
	task t_soft;
		bus(1, 6'h0c, 32'h00020000, 4'hf);
		bus(1, 6'h08, 32'h00020000, 4'h4);
		seen(4, 1);
		rchk(6'h08, 0);
		rchk(6'h14, 32'h00020000);
		bus(1, 6'h14, 32'h00020000, 4'hf);
	endtask
	task t_direct;
		bus(1, 6'h0c, 32'h20080000, 4'hf);
		SRC.pin(67, 1);
		seen(5, 1);
		SRC.pin(68, 1);
		seen(6, 1);
		bus(1, 6'h08, 32'h00080000, 4'hf);
		rchk(6'h14, 0);
	endtask
	task t_port;
		bus(1, 6'h18, 32'h00000020, 4'hf);
		bus(1, 6'h0c, 32'h00000004, 4'hf);
		bus(1, 6'h00, 32'h00000004, 4'hf);
		SRC.pin(34, 1);
		seen(1, 1);
		bus(1, 6'h0c, 32'h00010001, 4'hf);
		bus(1, 6'h00, 32'h00010001, 4'hf);
		SRC.pin(0, 0);
		SRC.pin(64, 1);
		seen(3, 1);
		SRC.pin(0, 1);
		seen(8, 1);
		chk("irq_0_1", 1, q[0]);
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 0;
		t_regs;
		t_gpio;
		t_mask;
		t_soft;
		t_direct;
		t_port;
		final_report;
	end
endmodule
